// ---- hdl/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
    // width of a conversion result
    localparam int RESULT_WIDTH = 12;
    // words held by the result fifo storage; the output stage holds one more
    localparam int FIFO_DEPTH = 16;
    // one comparator decision per bit
    localparam int CONV_BITS = 12;
    // track/hold acquisition cycles between continuous conversions
    localparam int ACQ_CYCLES = 2;
    // cycles of a triggered conversion: one start cycle plus the bits
    localparam int CONV_CYCLES = 1 + CONV_BITS;
    // cycles of one continuous conversion
    localparam int CONT_CYCLES = ACQ_CYCLES + CONV_BITS;
    // sar trial value for the first decision (msb)
    localparam logic [RESULT_WIDTH-1:0] SAR_FIRST_TRIAL = 12'h800;
    // offset binary to two's complement: invert the msb
    localparam logic [RESULT_WIDTH-1:0] TWOS_FLIP = 12'h800;
    // reset value of the result bus
    localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 12'h000;
    // index of the last decision
    localparam logic [3:0] LAST_BIT = 4'h0;
    // index of the first decision
    localparam logic [3:0] FIRST_BIT = 4'hB;
    // acquisition counter reload (counts down to zero)
    localparam logic [1:0] ACQ_LOAD = 2'h1;

    // level seen on the mode strap
    typedef enum logic [1:0] {
        STRAP_OPEN,
        STRAP_LOW,
        STRAP_HIGH
    } strap_type;
endpackage

// ---- hdl/result_stream_if.sv ----
`timescale 1ns/100ps
// carries conversion results from the control logic into the fifo
interface result_stream_if #(
    parameter int WIDTH = 12
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    // control logic pushes results
    modport src (output valid, output data, input ready);
    // fifo accepts them
    modport snk (input valid, input data, output ready);
endinterface

// ---- hdl/result_fifo.sv ----
`timescale 1ns/100ps
// result buffer: storage array plus a registered output stage
module result_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    result_stream_if.snk wr,
    output logic o_rd_valid,
    output logic [WIDTH-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next; // words in storage only
    logic out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg, out_data_next;
    logic push; // word accepted this cycle
    logic load; // word moved into the output stage

    // ready is honest: storage full means refuse
    assign wr.ready = (count_reg != DEPTH_C);
    assign o_rd_valid = out_valid_reg;
    assign o_rd_data = out_data_reg;

    // next state of pointers, count and output stage
    always_comb
    begin
        push = wr.valid & wr.ready;
        load = (~out_valid_reg | i_rd_ready) & (count_reg != '0);
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = load ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        out_data_next = load ? mem[rd_ptr_reg] : out_data_reg;
        if (load)
            out_valid_next = 1'b1;
        else if (i_rd_ready)
            out_valid_next = 1'b0;
        else
            out_valid_next = out_valid_reg;
    end

    // register state; clock enable low freezes everything
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end
        else if (i_clk_en)
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            out_valid_reg <= out_valid_next;
            out_data_reg <= out_data_next;
        end
    end

    // storage write port
    always_ff @(posedge i_sys_clk)
    begin
        if (i_clk_en && push)
            mem[wr_ptr_reg] <= wr.data;
    end

    a_fifo_count_bound: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) count_reg <= DEPTH_C)
        else $error("fifo count above depth");
    c_fifo_full: cover property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) count_reg == DEPTH_C);
endmodule

// ---- hdl/adc_conversion_mode_control.sv ----
`timescale 1ns/100ps
// Operation
// - stand-alone: a start falling edge while idle converts
// - always-on modes drive bus, update at end
// - slow-memory: read with select starts conversion
// - slow-memory: busy low for whole conversion
// - previous result stays until busy rises
// - rom: one access holds, starts, reads old
// - continuous: one conversion per 14 cycles
// - continuous: any control high stops conversions
// - decisions latched on rising clock edge only
// - results in two's complement, 4096 codes
// - busy low from start until result
// - conversion takes 13 or 14 cycles
// - start needs start low, no restart
module adc_conversion_mode_control #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire adc_ctrl_pkg::strap_type i_mode_strap,
    input wire logic i_convert_start_n,
    input wire logic i_read_n,
    input wire logic i_chip_select_n,
    input wire logic i_comp_above,
    output logic [WIDTH-1:0] o_result_bus_out,
    output logic o_result_bus_oe,
    output logic o_busy_n,
    output logic o_hold,
    output logic o_fifo_valid,
    output logic [WIDTH-1:0] o_fifo_data,
    input wire logic i_fifo_ready
);
    import adc_ctrl_pkg::*;

    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SYNC,
        ST_ACQ,
        ST_CONV
    } conv_state_type;

    conv_state_type state_reg, state_next;
    logic [3:0] bit_reg, bit_next; // index of the bit being decided
    logic [1:0] acq_reg, acq_next; // acquisition cycles left minus one
    logic [WIDTH-1:0] sar_reg, sar_next; // trial and kept bits
    logic [WIDTH-1:0] result_reg, result_next; // bus value
    logic busy_n_reg, busy_n_next;
    logic hold_reg, hold_next;
    logic oe_reg, oe_next;
    logic start_prev_reg, start_prev_next; // start condition last cycle
    logic push_reg, push_next; // one-cycle push into the fifo
    logic [WIDTH-1:0] push_data_reg, push_data_next;

    logic start_cond; // all three controls low
    logic start_edge; // start condition newly true
    logic cont_mode; // strap low selects continuous conversion
    logic cont_go; // continuous conversion may proceed
    logic [WIDTH-1:0] sar_decided; // sar with current decision applied
    logic conv_done; // last decision taken this cycle

    result_stream_if #(.WIDTH(WIDTH)) res_if ();

    // the fifo between conversion results and the drain port
    result_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .wr(res_if.snk),
        .o_rd_valid(o_fifo_valid),
        .o_rd_data(o_fifo_data),
        .i_rd_ready(i_fifo_ready)
    );

    assign res_if.valid = push_reg;
    assign res_if.data = push_data_reg;
    assign o_result_bus_out = result_reg;
    assign o_result_bus_oe = oe_reg;
    assign o_busy_n = busy_n_reg;
    assign o_hold = hold_reg;

    // decode of the control pins into trigger terms
    always_comb
    begin
        // same gate for modes 2 to 4: start low with read and select low
        start_cond = ~i_convert_start_n & ~i_read_n & ~i_chip_select_n;
        start_edge = start_cond & ~start_prev_reg;
        cont_mode = (i_mode_strap == STRAP_LOW);
        // fifo back-pressure stalls continuous conversion before it starts
        cont_go = cont_mode & start_cond & res_if.ready;
        // comparator high keeps the trial bit, low drops it
        sar_decided = sar_reg;
        if (!i_comp_above)
            sar_decided[bit_reg] = 1'b0;
        conv_done = (state_reg == ST_CONV) && (bit_reg == LAST_BIT);
    end

    // next-state logic of the sequencer, sar and outputs
    always_comb
    begin
        state_next = state_reg;
        bit_next = bit_reg;
        acq_next = acq_reg;
        sar_next = sar_reg;
        result_next = result_reg;
        push_next = 1'b0;
        push_data_next = push_data_reg;
        start_prev_next = start_cond;
        // bus modes float the bus outside an access
        oe_next = cont_mode | (~i_read_n & ~i_chip_select_n);
        case (state_reg)
            ST_IDLE:
            begin
                // only an idle sequencer starts a triggered conversion
                if (cont_mode)
                begin
                    if (cont_go)
                    begin
                        state_next = ST_ACQ;
                        acq_next = ACQ_LOAD;
                    end
                end
                else if (start_edge)
                begin
                    // enter hold now, first decision next cycle
                    state_next = ST_SYNC;
                end
            end
            ST_SYNC:
            begin
                state_next = ST_CONV;
                bit_next = FIRST_BIT;
                sar_next = SAR_FIRST_TRIAL;
            end
            ST_ACQ:
            begin
                // tracking for the acquisition cycles
                if (!cont_go)
                    state_next = ST_IDLE;
                else if (acq_reg == 2'h0)
                begin
                    state_next = ST_CONV;
                    bit_next = FIRST_BIT;
                    sar_next = SAR_FIRST_TRIAL;
                end
                else
                    acq_next = acq_reg - 2'h1;
            end
            ST_CONV:
            begin
                // one decision per rising edge
                sar_next = sar_decided;
                if (conv_done)
                begin
                    // result appears only at conversion end
                    result_next = sar_decided ^ TWOS_FLIP;
                    push_next = 1'b1;
                    push_data_next = sar_decided ^ TWOS_FLIP;
                    if (cont_go)
                    begin
                        state_next = ST_ACQ;
                        acq_next = ACQ_LOAD;
                    end
                    else
                        state_next = ST_IDLE;
                end
                else
                begin
                    bit_next = bit_reg - 4'h1;
                    sar_next[bit_reg - 4'h1] = 1'b1;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        // busy low and hold engaged while a conversion runs
        hold_next = (state_next == ST_SYNC) || (state_next == ST_CONV);
        busy_n_next = ~hold_next;
    end

    // registers; clock enable low freezes all state
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= ST_IDLE;
            bit_reg <= FIRST_BIT;
            acq_reg <= ACQ_LOAD;
            sar_reg <= RESULT_RESET;
            result_reg <= RESULT_RESET;
            busy_n_reg <= 1'b1;
            hold_reg <= 1'b0;
            oe_reg <= 1'b0;
            // treat the start condition as already true so a tied-low start gives no edge out of reset
            start_prev_reg <= 1'b1;
            push_reg <= 1'b0;
            push_data_reg <= RESULT_RESET;
        end
        else if (i_clk_en)
        begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            acq_reg <= acq_next;
            sar_reg <= sar_next;
            result_reg <= result_next;
            busy_n_reg <= busy_n_next;
            hold_reg <= hold_next;
            oe_reg <= oe_next;
            start_prev_reg <= start_prev_next;
            push_reg <= push_next;
            push_data_reg <= push_data_next;
        end
    end

    // checks assume the clock enable stays high
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n || !i_clk_en);

    a_edge_starts_conv: assert property (
        (state_reg == ST_IDLE && start_edge && !cont_mode)
        |=> state_reg == ST_SYNC ##1 state_reg == ST_CONV)
        else $error("start edge did not begin a conversion");
    a_triggered_length: assert property (
        ($fell(o_busy_n) && state_reg == ST_SYNC) |-> ##13 $rose(o_busy_n))
        else $error("triggered conversion not 13 cycles");
    a_cont_period: assert property (
        ($rose(o_busy_n) && state_reg == ST_ACQ) ##2 (state_reg == ST_CONV)
        |-> ##12 $rose(o_busy_n))
        else $error("continuous conversion not 14 cycles");
    a_busy_whole_conv: assert property (
        (state_reg == ST_CONV) |-> (!o_busy_n && o_hold))
        else $error("busy high during conversion");
    a_result_holds: assert property (
        !$rose(o_busy_n) |-> $stable(o_result_bus_out))
        else $error("result changed outside conversion end");
    a_no_restart: assert property (
        (state_reg == ST_CONV && bit_reg != LAST_BIT)
        |=> state_reg == ST_CONV && bit_reg == $past(bit_reg) - 4'h1)
        else $error("conversion restarted or skipped a bit");
    a_stop_when_high: assert property (
        (state_reg == ST_IDLE && cont_mode && !start_cond)
        |=> state_reg == ST_IDLE)
        else $error("continuous conversion with a control high");
    a_bus_float: assert property (
        (o_result_bus_oe && $past(i_mode_strap) != STRAP_LOW)
        |-> $past(!i_read_n && !i_chip_select_n))
        else $error("bus driven outside an access");
    a_twos_result: assert property (
        $rose(o_busy_n) |-> o_result_bus_out[WIDTH-1] == !$past(sar_decided[WIDTH-1]))
        else $error("result msb not two's complement");
    // hold and busy come from one next value, so they never part
    a_hold_mirrors_busy: assert property (
        o_hold == !o_busy_n)
        else $error("hold and busy disagree");
    // acquisition cycles track the input, so busy stays high there
    a_acq_busy_high: assert property (
        (state_reg == ST_ACQ) |-> (o_busy_n && !o_hold))
        else $error("busy low during acquisition");
    // continuous mode keeps the bus driven one cycle after the strap
    a_cont_bus_driven: assert property (
        ($past(i_mode_strap) == STRAP_LOW) |-> o_result_bus_oe)
        else $error("bus floated in continuous mode");
    // an idle triggered sequencer waits for a fresh start edge
    a_idle_needs_edge: assert property (
        (state_reg == ST_IDLE && !cont_mode && !start_edge)
        |=> state_reg == ST_IDLE)
        else $error("conversion began without a start edge");
    // start held high blocks every mode, continuous included
    a_start_high_blocks: assert property (
        (state_reg == ST_IDLE && i_convert_start_n)
        |=> state_reg == ST_IDLE)
        else $error("conversion began with start high");
    // the first decision always tries the msb
    a_sync_loads_msb: assert property (
        (state_reg == ST_SYNC)
        |=> (state_reg == ST_CONV && bit_reg == FIRST_BIT && sar_reg[WIDTH-1]))
        else $error("first decision not on the msb");
    // the fifo is offered the same word the bus shows at conversion end
    a_push_at_end: assert property (
        $rose(o_busy_n) |-> (res_if.valid && res_if.data == o_result_bus_out))
        else $error("result not offered to the fifo");

    c_triggered_conv: cover property (
        $fell(o_busy_n) && state_reg == ST_SYNC ##13 $rose(o_busy_n));
    c_cont_back_to_back: cover property (
        $rose(o_busy_n) && state_reg == ST_ACQ ##14 $rose(o_busy_n));
    c_bus_access: cover property (o_result_bus_oe && !cont_mode && !o_busy_n);
    c_fifo_stall: cover property (cont_mode && start_cond && !res_if.ready);
endmodule

// ---- sim/result_sink.sv ----
`timescale 1ns/100ps
// drain side of the result fifo: takes words at a random pace
module result_sink
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_stall,
    output logic o_ready
);
    // random gaps give back-pressure; stall holds ready low to fill up
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_ready <= 1'b0;
        else
            o_ready <= !i_stall && ($urandom % 4 != 0);
    end
endmodule

// ---- sim/adc_conversion_mode_control_tb.sv ----
`timescale 1ns/100ps
module adc_conversion_mode_control_tb;
    import adc_ctrl_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    strap_type strap = STRAP_OPEN;
    logic start_n = 1'b1;
    logic read_n = 1'b1;
    logic cs_n = 1'b1;
    logic comp = 1'b0;
    logic stall = 1'b0;
    logic [11:0] result;
    logic [11:0] f_data;
    logic oe, busy_n, hold, f_valid, f_ready;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    // model state: decisions, last result, fifo contents
    logic [11:0] sar_sr = 12'h000;
    logic [11:0] last_exp = RESULT_RESET;
    logic [11:0] exp_q[$];
    logic oe_exp = 1'b0;
    logic busy_d = 1'b1;
    int low_len = 0;
    int gap = 0;
    int n_conv = 0;
    int n0;
    strap_type modes[2] = '{STRAP_OPEN, STRAP_HIGH};

    adc_conversion_mode_control u_adc_conversion_mode_control (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
        .i_mode_strap(strap), .i_convert_start_n(start_n),
        .i_read_n(read_n), .i_chip_select_n(cs_n), .i_comp_above(comp),
        .o_result_bus_out(result), .o_result_bus_oe(oe),
        .o_busy_n(busy_n), .o_hold(hold), .o_fifo_valid(f_valid),
        .o_fifo_data(f_data), .i_fifo_ready(f_ready)
    );

    result_sink u_result_sink (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_stall(stall),
        .o_ready(f_ready)
    );

    // 40 MHz; the cycle model has no analog acquisition limit
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // set the three controls at an edge, then hold them n cycles
    task automatic ctl(input logic s, input logic r, input logic c,
                       input int n);
        @(posedge sys_clk);
        start_n <= s;
        read_n <= r;
        cs_n <= c;
        repeat (n) @(posedge sys_clk);
    endtask

    // bounded wait for the converter to go idle, plus acquisition slack
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy_n !== 1'b1 && k < 40)
        begin
            @(posedge sys_clk);
            k++;
        end
        repeat (4) @(posedge sys_clk);
    endtask

    // comparator decisions are random, one per clock
    always @(posedge sys_clk)
        comp <= 1'($urandom % 2);

    // edge-side model: decisions, bus enable, drained words, timeout
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            fails++;
            report_and_stop();
        end
        if (busy_n === 1'b0)
            sar_sr <= {sar_sr[10:0], comp};
        oe_exp <= rst_n && ((strap == STRAP_LOW) || (!read_n && !cs_n));
        if (f_valid === 1'b1 && f_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(f_data, 32'hFFFF_FFFF);
            else
                check(f_data, exp_q.pop_front());
        end
    end

    // mid-cycle checks where outputs have settled
    always @(negedge sys_clk)
    begin
        if (rst_n)
        begin
            check(oe, oe_exp);
            check(hold, !busy_n);
            if (busy_n === 1'b0)
                low_len++;
            gap++;
            if (busy_n === 1'b1 && busy_d === 1'b0)
            begin
                check(low_len, strap == STRAP_LOW ? CONV_BITS : CONV_CYCLES);
                if (strap == STRAP_LOW && gap <= 20)
                    check(gap, CONT_CYCLES);
                last_exp = sar_sr ^ TWOS_FLIP;
                check(result, last_exp);
                exp_q.push_back(last_exp);
                low_len = 0;
                gap = 0;
                n_conv++;
            end
            else
                check(result, last_exp);
            busy_d = busy_n;
        end
    end

    initial
    begin
        void'($urandom(32'hE36003E9));
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check({busy_n, oe, f_valid}, 3'b100);
        @(posedge sys_clk);
        // stand-alone: strap open then high, read and select low
        foreach (modes[m])
        begin
            strap <= modes[m];
            ctl(1'b1, 1'b0, 1'b0, 3);
            repeat (4)
            begin
                n0 = n_conv;
                ctl(1'b0, 1'b0, 1'b0, 3);
                // start toggling mid-conversion must not restart it
                ctl(1'b1, 1'b0, 1'b0, 2);
                ctl(1'b0, 1'b0, 1'b0, 2);
                wait_idle();
                ctl(1'b1, 1'b0, 1'b0, 2);
                check(n_conv, n0 + 1);
            end
        end
        // slow-memory and rom: start held low, access starts a conversion
        strap <= STRAP_OPEN;
        ctl(1'b0, 1'b1, 1'b1, 3);
        repeat (6)
        begin
            n0 = n_conv;
            ctl(1'b0, 1'b0, 1'b0, $urandom_range(1, 3));
            ctl(1'b0, 1'b1, 1'b1, 1);
            wait_idle();
            check(n_conv, n0 + 1);
        end
        // half an access or start held high starts nothing
        n0 = n_conv;
        ctl(1'b0, 1'b1, 1'b0, 4);
        ctl(1'b1, 1'b1, 1'b1, 2);
        ctl(1'b1, 1'b0, 1'b0, 20);
        check(n_conv, n0);
        // continuous: strap low and all controls low
        ctl(1'b1, 1'b1, 1'b1, 25);
        strap <= STRAP_LOW;
        ctl(1'b0, 1'b0, 1'b0, 5 * CONT_CYCLES);
        for (int i = 0; i < 3; i++)
        begin
            ctl(i != 0, i != 1, i != 2, 16);
            n0 = n_conv;
            repeat (30) @(posedge sys_clk);
            check(n_conv, n0);
            ctl(1'b0, 1'b0, 1'b0, 40);
            check(n_conv > n0, 1'b1);
        end
        // stalled drain: buffer fills and conversions stop
        stall <= 1'b1;
        repeat (25 * CONT_CYCLES) @(posedge sys_clk);
        n0 = n_conv;
        repeat (30) @(posedge sys_clk);
        check(n_conv, n0);
        check(exp_q.size() >= FIFO_DEPTH, 1'b1);
        stall <= 1'b0;
        ctl(1'b0, 1'b0, 1'b1, 200);
        check(exp_q.size(), 0);
        report_and_stop();
    end
endmodule
